// ---- inc/cycle_sel_map.vh ----
// Constants for the memory cycle type selector: field positions, codes and counts.
// Assumes inclusion by bare name from design files.
`ifndef CYCLE_SEL_MAP_VH
`define CYCLE_SEL_MAP_VH
// -----------------------------------------------------------------------------
// Command and address field positions
// -----------------------------------------------------------------------------
`define CMD_HI 27
`define CMD_LO 25
`define ADDR_PROM_BIT 10
// -----------------------------------------------------------------------------
// Command codes on bits 27 to 25
// -----------------------------------------------------------------------------
`define CMD_READ 3'h0
`define CMD_READ_LOCK 3'h1
`define CMD_WRITE 3'h2
`define CMD_WRITE_UNLOCK 3'h3
// -----------------------------------------------------------------------------
// Region match values
// -----------------------------------------------------------------------------
`define REGION_MATCH 13'h1F80
`define CSR_MATCH 6'h00
// -----------------------------------------------------------------------------
// Microcode starting addresses
// -----------------------------------------------------------------------------
`define RSA_IDLE 4'h0
`define RSA_CSR1_WR 4'h1
`define RSA_CSR0_WR 4'h2
`define RSA_CSR_RD 4'h3
`define RSA_ROM_RD 4'h4
`define RSA_ILL_CSR 4'h5
`define RSA_INIT 4'h6
`define RSA_UNUSED 4'h7
`define RSA_LW_WR 4'h8
`define RSA_LW_WR_NOECC 4'h9
`define RSA_REFRESH 4'hA
`define RSA_BYTE_WR 4'hB
`define RSA_DIAG_OUT_PG 4'hC
`define RSA_DIAG_IN_PG 4'hD
`define RSA_RD 4'hE
`define RSA_RD_NOECC 4'hF
// -----------------------------------------------------------------------------
// Data path output codes
// -----------------------------------------------------------------------------
`define OUT_NONE 2'h0
`define OUT_ROM_RD 2'h1
`define OUT_CSR_RD 2'h2
`define OUT_CSR_WR 2'h3
// -----------------------------------------------------------------------------
// Sequencer and timing
// -----------------------------------------------------------------------------
`define SEQ_IDLE_ADDR 8'h00
`define SLOW_SYNC_STAGES 4
`define NIBBLES_PER_WORD 8
`endif

// ---- design/prom_word_assembler.v ----
// Assembles 4-bit bootstrap PROM nibbles into a 32-bit word.
// Assumes a single clock and a one-cycle strobe per valid nibble.
`timescale 1ns/1ns
module prom_word_assembler (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire clear_i,
  input wire nibble_stb_i,
  input wire [2:0] nibble_idx_i,
  input wire [3:0] nibble_i,
  output reg [31:0] word_o,
  output reg word_valid_o
);
  // ---------------------------------------------------------------------------
  // Nibble storage
  // ---------------------------------------------------------------------------
  // Each strobed nibble lands in its slot; the last slot completes the word.
  always @(posedge sys_clk_i) begin
    if (!rst_b_i || clear_i) begin
      word_o <= 32'h00000000;
      word_valid_o <= 1'b0;
    end else begin
      word_valid_o <= 1'b0;
      if (nibble_stb_i) begin
        case (nibble_idx_i)
          3'h0: word_o[3:0] <= nibble_i;
          3'h1: word_o[7:4] <= nibble_i;
          3'h2: word_o[11:8] <= nibble_i;
          3'h3: word_o[15:12] <= nibble_i;
          3'h4: word_o[19:16] <= nibble_i;
          3'h5: word_o[23:20] <= nibble_i;
          3'h6: word_o[27:24] <= nibble_i;
          default: word_o[31:28] <= nibble_i;
        endcase
        if (nibble_idx_i == 3'h7) begin
          word_valid_o <= 1'b1;
        end
      end
    end
  end
endmodule // prom_word_assembler

// ---- design/memory_cycle_type_selector.v ----
// Front-end decode and cycle type selection for a MOS memory controller.
// Assumes bus clock and oscillator arrive as pins sampled by sys_clk_i.
`timescale 1ns/1ns
`include "cycle_sel_map.vh"
module memory_cycle_type_selector (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire bus_clock_i,
  input wire internal_oscillator_i,
  input wire fast_speed_select_i,
  input wire bus_hold_busy_b_i,
  input wire [31:0] bus_data_i,
  input wire memory_present_i,
  input wire [7:0] sequencer_address_i,
  input wire refresh_request_i,
  input wire init_active_i,
  input wire diag_check_i,
  input wire correction_disable_i,
  input wire diag_in_page_i,
  input wire [3:0] prom_nibble_data_i,
  input wire nibble_stb_i,
  input wire cycle_done_i,
  output reg rw_operand_o,
  output reg no_cycle_flag_o,
  output reg csr_or_prom_region_hit_b_o,
  output reg prom_cycle_request_o,
  output reg csr_cycle_request_o,
  output reg [3:0] prom_chip_select_b_o,
  output reg [8:0] prom_address_o,
  output reg [1:0] csr_read_select_b_o,
  output reg [1:0] datapath_output_code_o,
  output reg memory_request_o,
  output reg csr_request_o,
  output reg prom_request_o,
  output reg refresh_next_o,
  output reg refresh_or_cycle_zero_o,
  output reg [3:0] microcode_start_address_o,
  output reg init_cycle_b_o,
  output reg refresh_cycle_b_o,
  output reg illegal_csr_write_b_o,
  output reg busy_release_o,
  output reg diag_check_substitute_b_o,
  output reg ecc_bypass_o,
  output reg [31:0] prom_word_o,
  output reg prom_word_valid_o
);
  // ---------------------------------------------------------------------------
  // State codes
  // ---------------------------------------------------------------------------
  localparam ST_IDLE = 2'b01;
  localparam ST_RUN = 2'b10;

  // Decodes a command code into a read operand flag.
  function is_read;
    input [2:0] cmd;
    begin
      is_read = (cmd == `CMD_READ) || (cmd == `CMD_READ_LOCK);
    end
  endfunction

  // Decodes a command code into a legal-code flag.
  function is_legal;
    input [2:0] cmd;
    begin
      is_legal = (cmd == `CMD_READ) || (cmd == `CMD_READ_LOCK) ||
                 (cmd == `CMD_WRITE) || (cmd == `CMD_WRITE_UNLOCK);
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  reg [1:0] bclk_sync_reg;
  reg [1:0] osc_sync_reg;
  reg [1:0] busy_sync_reg;
  reg [1:0] fast_sync_reg;
  reg bclk_prev_reg;
  reg osc_prev_reg;
  // Two flip-flops on the bus clock, oscillator, busy and speed-select pins before use.
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      bclk_sync_reg <= 2'b00;
      osc_sync_reg <= 2'b00;
      busy_sync_reg <= 2'b11;
      fast_sync_reg <= 2'b00;
      bclk_prev_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
    end else begin
      bclk_sync_reg <= {bclk_sync_reg[0], bus_clock_i};
      osc_sync_reg <= {osc_sync_reg[0], internal_oscillator_i};
      busy_sync_reg <= {busy_sync_reg[0], bus_hold_busy_b_i};
      fast_sync_reg <= {fast_sync_reg[0], fast_speed_select_i};
      bclk_prev_reg <= bclk_sync_reg[1];
      osc_prev_reg <= osc_sync_reg[1];
    end
  end

  wire bclk_en = bclk_sync_reg[1] & ~bclk_prev_reg;
  wire osc_en = osc_sync_reg[1] & ~osc_prev_reg;
  wire fast_mode = fast_sync_reg[1];
  wire busy_now = ~busy_sync_reg[1];

  // ---------------------------------------------------------------------------
  // Address cycle capture and decode
  // ---------------------------------------------------------------------------
  reg busy_was_reg;
  reg [2:0] cmd_reg;
  reg all_bytes_reg;
  reg [23:0] addr_reg;
  reg req_mem_reg;
  reg req_csr_reg;
  reg req_rom_reg;
  wire [2:0] cmd_now = bus_data_i[`CMD_HI:`CMD_LO];
  wire new_req = bclk_en & busy_now & ~busy_was_reg;
  wire legal_now = is_legal(cmd_now);
  wire region_hit = (bus_data_i[23:11] == `REGION_MATCH);
  wire region_req = new_req & legal_now & region_hit;
  wire rom_hit = region_req & bus_data_i[`ADDR_PROM_BIT];
  wire csr_hit = region_req & ~bus_data_i[`ADDR_PROM_BIT] & (bus_data_i[9:4] == `CSR_MATCH);
  wire mem_hit = new_req & legal_now & ~region_hit & memory_present_i;

  // Latch command and address at the bus clock edge of a new request.
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      busy_was_reg <= 1'b0;
      cmd_reg <= 3'h7;
      all_bytes_reg <= 1'b1;
      addr_reg <= 24'h000000;
      req_mem_reg <= 1'b0;
      req_csr_reg <= 1'b0;
      req_rom_reg <= 1'b0;
      rw_operand_o <= 1'b0;
      no_cycle_flag_o <= 1'b1;
      csr_or_prom_region_hit_b_o <= 1'b1;
      prom_cycle_request_o <= 1'b0;
      csr_cycle_request_o <= 1'b0;
    end else if (bclk_en) begin
      busy_was_reg <= busy_now;
      req_mem_reg <= mem_hit;
      req_csr_reg <= csr_hit;
      req_rom_reg <= rom_hit;
      csr_or_prom_region_hit_b_o <= ~region_req;
      prom_cycle_request_o <= rom_hit;
      csr_cycle_request_o <= csr_hit;
      if (new_req) begin
        cmd_reg <= cmd_now;
        all_bytes_reg <= (bus_data_i[31:28] == 4'hF);
        addr_reg <= bus_data_i[23:0];
        rw_operand_o <= is_read(cmd_now);
        no_cycle_flag_o <= ~legal_now;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Request synchronisation to the controller clock
  // ---------------------------------------------------------------------------
  reg [3:0] slow_mem_reg;
  reg [3:0] slow_csr_reg;
  reg [3:0] slow_rom_reg;
  reg [3:0] slow_ref_reg;
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      slow_mem_reg <= 4'h0;
      slow_csr_reg <= 4'h0;
      slow_rom_reg <= 4'h0;
      slow_ref_reg <= 4'h0;
    end else if (osc_en) begin
      slow_mem_reg <= {slow_mem_reg[2:0], req_mem_reg};
      slow_csr_reg <= {slow_csr_reg[2:0], req_csr_reg};
      slow_rom_reg <= {slow_rom_reg[2:0], req_rom_reg};
      slow_ref_reg <= {slow_ref_reg[2:0], refresh_request_i};
    end
  end

  wire phase0_en = fast_mode ? bclk_en : osc_en;
  wire mem_req_mux = fast_mode ? req_mem_reg : slow_mem_reg[`SLOW_SYNC_STAGES - 1];
  wire csr_req_mux = fast_mode ? req_csr_reg : slow_csr_reg[`SLOW_SYNC_STAGES - 1];
  wire rom_req_mux = fast_mode ? req_rom_reg : slow_rom_reg[`SLOW_SYNC_STAGES - 1];
  wire ref_next_mux = fast_mode ? refresh_request_i : slow_ref_reg[`SLOW_SYNC_STAGES - 1];

  // ---------------------------------------------------------------------------
  // Cycle type selection
  // ---------------------------------------------------------------------------
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [3:0] rsa_next;
  reg ill_next;
  reg ref_cy_next;
  reg init_cy_next;
  wire rd_op = is_read(cmd_reg);
  wire wr_op = ~rd_op & ~no_cycle_flag_o;
  wire [1:0] csr_idx = addr_reg[3:2];

  // Picks the starting address for the next cycle.
  always @* begin
    state_next = state_reg;
    rsa_next = `RSA_IDLE;
    ill_next = 1'b0;
    ref_cy_next = 1'b0;
    init_cy_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (refresh_or_cycle_zero_o && refresh_request_i) begin
          if (init_active_i) begin
            init_cy_next = 1'b1;
            rsa_next = `RSA_INIT;
          end else begin
            ref_cy_next = 1'b1;
            rsa_next = `RSA_REFRESH;
          end
          state_next = ST_RUN;
        end else if (init_active_i) begin
          rsa_next = `RSA_IDLE;
        end else if (rom_req_mux) begin
          rsa_next = `RSA_ROM_RD;
          state_next = ST_RUN;
        end else if (csr_req_mux) begin
          state_next = ST_RUN;
          if (rd_op) begin
            rsa_next = `RSA_CSR_RD;
          end else if (csr_idx == 2'h0) begin
            rsa_next = `RSA_CSR0_WR;
          end else if (csr_idx == 2'h1) begin
            rsa_next = `RSA_CSR1_WR;
          end else begin
            rsa_next = `RSA_ILL_CSR;
            ill_next = 1'b1;
          end
        end else if (mem_req_mux) begin
          state_next = ST_RUN;
          if (rd_op) begin
            if (correction_disable_i) begin
              rsa_next = `RSA_RD_NOECC;
            end else if (diag_check_i) begin
              rsa_next = diag_in_page_i ? `RSA_DIAG_IN_PG : `RSA_DIAG_OUT_PG;
            end else begin
              rsa_next = `RSA_RD;
            end
          end else if (wr_op && !all_bytes_reg) begin
            rsa_next = `RSA_BYTE_WR;
          end else begin
            rsa_next = correction_disable_i ? `RSA_LW_WR_NOECC : `RSA_LW_WR;
          end
        end else begin
          rsa_next = `RSA_IDLE;
        end
      end
      ST_RUN: begin
        if (cycle_done_i) begin
          state_next = ST_IDLE;
        end
        rsa_next = `RSA_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Registers the starting address and cycle strobes on the phase-0 enable.
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_IDLE;
      microcode_start_address_o <= `RSA_IDLE;
      init_cycle_b_o <= 1'b1;
      refresh_cycle_b_o <= 1'b1;
      illegal_csr_write_b_o <= 1'b1;
      busy_release_o <= 1'b0;
      refresh_or_cycle_zero_o <= 1'b1;
      memory_request_o <= 1'b0;
      csr_request_o <= 1'b0;
      prom_request_o <= 1'b0;
      refresh_next_o <= 1'b0;
    end else if (phase0_en) begin
      state_reg <= state_next;
      microcode_start_address_o <= rsa_next;
      init_cycle_b_o <= ~init_cy_next;
      refresh_cycle_b_o <= ~ref_cy_next;
      illegal_csr_write_b_o <= ~ill_next;
      busy_release_o <= ill_next;
      refresh_or_cycle_zero_o <= (sequencer_address_i == `SEQ_IDLE_ADDR);
      memory_request_o <= mem_req_mux;
      csr_request_o <= csr_req_mux;
      prom_request_o <= rom_req_mux;
      refresh_next_o <= ref_next_mux;
    end
  end

  // ---------------------------------------------------------------------------
  // PROM, CSR and data path controls
  // ---------------------------------------------------------------------------
  wire rom_cycle = (microcode_start_address_o == `RSA_ROM_RD);
  wire csr_rd_cycle = (microcode_start_address_o == `RSA_CSR_RD);
  wire csr_wr_cycle = (microcode_start_address_o == `RSA_CSR0_WR) ||
                      (microcode_start_address_o == `RSA_CSR1_WR);
  // Drives selects from the held address, the PROM address from the held and sequencer addresses, and the output code from the start code.
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      prom_chip_select_b_o <= 4'hF;
      prom_address_o <= 9'h000;
      csr_read_select_b_o <= 2'h3;
      datapath_output_code_o <= `OUT_NONE;
      diag_check_substitute_b_o <= 1'b1;
      ecc_bypass_o <= 1'b0;
    end else begin
      prom_chip_select_b_o <= ~(4'h1 << addr_reg[9:8]);
      prom_address_o <= {addr_reg[7:2], sequencer_address_i[3:1]};
      csr_read_select_b_o <= csr_rd_cycle ? ~csr_idx : 2'h3;
      if (rom_cycle) begin
        datapath_output_code_o <= `OUT_ROM_RD;
      end else if (csr_rd_cycle) begin
        datapath_output_code_o <= `OUT_CSR_RD;
      end else if (csr_wr_cycle) begin
        datapath_output_code_o <= `OUT_CSR_WR;
      end else begin
        datapath_output_code_o <= `OUT_NONE;
      end
      diag_check_substitute_b_o <= ~(diag_check_i & ~correction_disable_i);
      ecc_bypass_o <= correction_disable_i;
    end
  end

  // ---------------------------------------------------------------------------
  // PROM word assembly
  // ---------------------------------------------------------------------------
  wire [31:0] asm_word;
  wire asm_valid;
  prom_word_assembler u_asm (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .clear_i(1'b0),
    .nibble_stb_i(nibble_stb_i & rom_cycle),
    .nibble_idx_i(sequencer_address_i[3:1]),
    .nibble_i(prom_nibble_data_i),
    .word_o(asm_word),
    .word_valid_o(asm_valid)
  );

  // Registers the assembled word for output.
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      prom_word_o <= 32'h00000000;
      prom_word_valid_o <= 1'b0;
    end else begin
      prom_word_o <= asm_word;
      prom_word_valid_o <= asm_valid;
    end
  end
endmodule // memory_cycle_type_selector

// ---- verification/bus_master_model.sv ----
// Bus master model: makes the bus clock and opens one address cycle per request.
// Assumes the bench holds req_i until busy is seen low.
`timescale 1ns/1ns
module bus_master_model (
  input wire sys_clk_i,
  input wire req_i,
  input wire [31:0] data_i,
  output reg bus_clock_o,
  output reg bus_hold_busy_b_o,
  output reg [31:0] bus_data_o
);
  reg [4:0] phase_reg;
  initial begin
    phase_reg = 5'h00;
    bus_clock_o = 1'b0;
    bus_hold_busy_b_o = 1'b1;
    bus_data_o = 32'h00000000;
  end
  // Bus clock of 40 system cycles; every change lands on its rising edge.
  // busy asserted for one bus period only
  always @(posedge sys_clk_i) begin
    phase_reg <= (phase_reg == 5'h13) ? 5'h00 : phase_reg + 5'h01;
    if (phase_reg == 5'h13) begin
      bus_clock_o <= ~bus_clock_o;
      if (!bus_clock_o && req_i && bus_hold_busy_b_o) begin
        bus_hold_busy_b_o <= 1'b0;
        bus_data_o <= data_i;
      end else if (!bus_clock_o) begin
        bus_hold_busy_b_o <= 1'b1; // Pulled up when released.
        bus_data_o <= ~bus_data_o; // Released lines do not keep the old value.
      end
    end
  end
endmodule // bus_master_model

// ---- verification/memory_cycle_type_selector_properties.sv ----
// Checker for the memory cycle type selector, bound to its top module.
// Assumes the constants header is on the include path.
`timescale 1ns/1ns
`include "cycle_sel_map.vh"
module memory_cycle_type_selector_properties (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire correction_disable_i,
  input wire diag_check_i,
  input wire [3:0] prom_chip_select_b_o,
  input wire [1:0] csr_read_select_b_o,
  input wire [1:0] datapath_output_code_o,
  input wire [3:0] microcode_start_address_o,
  input wire init_cycle_b_o,
  input wire refresh_cycle_b_o,
  input wire illegal_csr_write_b_o,
  input wire busy_release_o,
  input wire diag_check_substitute_b_o,
  input wire ecc_bypass_o,
  input wire prom_word_valid_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // All checks use the system clock and pause in reset.
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_one_prom_sel: assert property ($onehot0(~prom_chip_select_b_o))
    else $error("more than one PROM selected");
  chk_csr_sel_idle: assert property (microcode_start_address_o != `RSA_CSR_RD &&
    $past(microcode_start_address_o) != `RSA_CSR_RD |-> csr_read_select_b_o == 2'h3)
    else $error("CSR read select outside a CSR read");
  chk_rom_out_code: assert property ($rose(microcode_start_address_o == `RSA_ROM_RD) |->
    ##[0:2] datapath_output_code_o == `OUT_ROM_RD) else $error("no ROM read output code");
  chk_init_ref_excl: assert property (!(!init_cycle_b_o && !refresh_cycle_b_o))
    else $error("init and refresh cycles together");
  chk_illegal_release: assert property ($fell(illegal_csr_write_b_o) |-> ##[0:1] busy_release_o)
    else $error("illegal CSR op without busy release");
  chk_diag_subst: assert property ((diag_check_i && !correction_disable_i)[*2] |->
    !diag_check_substitute_b_o) else $error("check bits not substituted");
  chk_ecc_bypass: assert property (correction_disable_i ##1 correction_disable_i |-> ecc_bypass_o)
    else $error("correction not bypassed");
  chk_word_pulse: assert property (prom_word_valid_o |=> !prom_word_valid_o)
    else $error("word valid longer than one cycle");
  chk_no_unused_code: assert property (microcode_start_address_o != `RSA_UNUSED)
    else $error("unused start code issued");
  chk_code_stands: assert property ($changed(microcode_start_address_o) &&
    microcode_start_address_o != `RSA_IDLE |=> $stable(microcode_start_address_o)[*8])
    else $error("start code did not stand");
  cov_refresh: cover property (microcode_start_address_o == `RSA_REFRESH);
  cov_rom: cover property (prom_word_valid_o);
  cov_illegal: cover property (!illegal_csr_write_b_o);
endmodule // memory_cycle_type_selector_properties

// ---- verification/testbench.sv ----
// Self-checking bench for the memory cycle type selector with a bus master model.
// Assumes the design, master model and checker are compiled first.
`timescale 1ns/1ns
`include "cycle_sel_map.vh"
module testbench;
  reg sys_clk_i, rst_b_i, internal_oscillator_i, fast_speed_select_i, memory_present_i, refresh_request_i;
  reg init_active_i, diag_check_i, correction_disable_i, diag_in_page_i, nibble_stb_i, cycle_done_i, req;
  reg [7:0] sequencer_address_i;
  reg [3:0] prom_nibble_data_i, got;
  reg [31:0] req_data, w, d;
  integer num_errors, checks_done, n, i;
  wire bus_clock_i, bus_hold_busy_b_i, rw_operand_o, no_cycle_flag_o, refresh_or_cycle_zero_o, prom_word_valid_o;
  wire [31:0] bus_data_i, prom_word_o;
  wire [3:0] prom_chip_select_b_o, microcode_start_address_o;
  wire [8:0] prom_address_o;
  wire [1:0] csr_read_select_b_o, datapath_output_code_o;
  bus_master_model master (.sys_clk_i, .req_i(req), .data_i(req_data), .bus_clock_o(bus_clock_i),
    .bus_hold_busy_b_o(bus_hold_busy_b_i), .bus_data_o(bus_data_i));
  memory_cycle_type_selector dut (.sys_clk_i, .rst_b_i, .bus_clock_i, .internal_oscillator_i,
    .fast_speed_select_i, .bus_hold_busy_b_i, .bus_data_i, .memory_present_i, .sequencer_address_i,
    .refresh_request_i, .init_active_i, .diag_check_i, .correction_disable_i, .diag_in_page_i,
    .prom_nibble_data_i, .nibble_stb_i, .cycle_done_i, .rw_operand_o, .no_cycle_flag_o,
    .csr_or_prom_region_hit_b_o(), .prom_cycle_request_o(), .csr_cycle_request_o(), .prom_chip_select_b_o,
    .prom_address_o, .csr_read_select_b_o, .datapath_output_code_o, .memory_request_o(), .csr_request_o(),
    .prom_request_o(), .refresh_next_o(), .refresh_or_cycle_zero_o, .microcode_start_address_o,
    .init_cycle_b_o(), .refresh_cycle_b_o(), .illegal_csr_write_b_o(), .busy_release_o(),
    .diag_check_substitute_b_o(), .ecc_bypass_o(), .prom_word_o, .prom_word_valid_o);
  // ----------------------------------------
  // Expectations and checking
  // ----------------------------------------
  // Start code for an address cycle; m holds in-page, diagnostic and correction-disable.
  function [3:0] exp_code(input [31:0] dv, input [2:0] m);
    reg rd;
    begin
      rd = (dv[27:25] < 3'h2);
      if (dv[27]) exp_code = `RSA_IDLE;
      else if (dv[23:11] == `REGION_MATCH) exp_code = dv[10] ? `RSA_ROM_RD : rd ? `RSA_CSR_RD :
        (dv[3:2] == 2'h0) ? `RSA_CSR0_WR : (dv[3:2] == 2'h1) ? `RSA_CSR1_WR : `RSA_ILL_CSR;
      else if (rd) exp_code = m[0] ? `RSA_RD_NOECC : !m[1] ? `RSA_RD : m[2] ? `RSA_DIAG_IN_PG : `RSA_DIAG_OUT_PG;
      else exp_code = (dv[31:28] != 4'hF) ? `RSA_BYTE_WR : m[0] ? `RSA_LW_WR_NOECC : `RSA_LW_WR;
    end
  endfunction
  task compare(input string what, input [31:0] exp, input [31:0] seen);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("BAD %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // One bus cycle: wait for the start code, check side outputs, then end the cycle.
  task op(input [31:0] dv, input [3:0] e, input rf);
    begin
      @(posedge sys_clk_i);
      req <= 1'b1;
      req_data <= dv;
      refresh_request_i <= rf;
      for (n = 0; n < 60 && bus_hold_busy_b_i !== 1'b0; n = n + 1) @(posedge sys_clk_i);
      req <= 1'b0;
      got = 4'h0;
      for (n = 0; n < 300 && got === 4'h0; n = n + 1) begin
        @(negedge sys_clk_i);
        got = microcode_start_address_o;
      end
      @(negedge sys_clk_i); // Select and output code are registered one cycle after the start code.
      compare("start code", {28'h0, e}, {28'h0, got});
      if (e == `RSA_CSR_RD) compare("csr select", {30'h0, ~dv[3:2]}, {30'h0, csr_read_select_b_o});
      if (e >= 4'h1 && e <= 4'h4) compare("out code", {30'h0, (e == 4'h4) ? 2'h1 : (e == 4'h3) ? 2'h2 : 2'h3},
        {30'h0, datapath_output_code_o});
      if (e == `RSA_ROM_RD) begin
        compare("prom select", {28'h0, ~(4'h1 << dv[9:8])}, {28'h0, prom_chip_select_b_o});
        compare("prom addr", {26'h0, dv[7:2]}, {26'h0, prom_address_o[8:3]});
        w = $urandom;
        for (i = 0; i < 8; i = i + 1) begin
          @(posedge sys_clk_i);
          sequencer_address_i <= {4'h0, i[2:0], 1'b0};
          prom_nibble_data_i <= w[4*i +: 4];
          nibble_stb_i <= 1'b1;
        end
        @(posedge sys_clk_i);
        nibble_stb_i <= 1'b0;
        sequencer_address_i <= 8'h00;
        for (n = 0; n < 20 && prom_word_valid_o !== 1'b1; n = n + 1) @(negedge sys_clk_i);
        compare("prom word", w, prom_word_o);
      end
      @(posedge sys_clk_i);
      refresh_request_i <= 1'b0;
      cycle_done_i <= 1'b1;
      repeat (100) @(posedge sys_clk_i);
      cycle_done_i <= 1'b0;
      repeat (80) @(posedge sys_clk_i);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // ----------------------------------------
  // Clocks, watchdog and tests
  // ----------------------------------------
  // System clock and an unrelated slow oscillator.
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    internal_oscillator_i = 1'b0;
    forever #32 internal_oscillator_i = ~internal_oscillator_i;
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    num_errors = num_errors + 1;
    conclude;
  end
  // Main sequence.
  initial begin
    {rst_b_i, memory_present_i, fast_speed_select_i} = 3'b011;
    {refresh_request_i, init_active_i, diag_check_i, correction_disable_i, diag_in_page_i} = 5'h00;
    {nibble_stb_i, cycle_done_i, req} = 3'b000;
    sequencer_address_i = 8'h00;
    prom_nibble_data_i = 4'h0;
    req_data = 32'h00000000;
    num_errors = 0;
    checks_done = 0;
    w = $urandom(78);
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    compare("reset select", 32'hF, {28'h0, prom_chip_select_b_o});
    compare("reset ref zero", 32'h1, {31'h0, refresh_or_cycle_zero_o});
    compare("reset no cycle", 32'h1, {31'h0, no_cycle_flag_o});
    @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    for (i = 0; i < 8; i = i + 1) begin
      d = {4'hF, i[2:0], 25'h0001230};
      op(d, exp_code(d, 3'h0), 1'b0);
      compare("no cycle", {31'h0, d[27]}, {31'h0, no_cycle_flag_o});
      compare("rw operand", {31'h0, d[27:25] < 3'h2}, {31'h0, rw_operand_o});
    end
    $display("test commands done");
    for (i = 0; i < 8; i = i + 1) begin
      {diag_in_page_i, diag_check_i, correction_disable_i} <= i[2:0];
      op(32'hF000ABC0, exp_code(32'hF000ABC0, i[2:0]), 1'b0);
      op(32'hF400ABC0, exp_code(32'hF400ABC0, i[2:0]), 1'b0);
    end
    {diag_in_page_i, diag_check_i, correction_disable_i} <= 3'h0;
    $display("test modes done");
    for (i = 0; i < 12; i = i + 1) begin
      d = $urandom;
      d[27] = 1'b0;
      d[23] = 1'b0;
      op(d, exp_code(d, 3'h0), 1'b0);
    end
    $display("test random memory done");
    for (i = 0; i < 8; i = i + 1) begin
      d = {4'hF, i[2] ? 3'h2 : 3'h0, 1'b0, 20'hFC000, i[1:0], 2'h0};
      op(d, exp_code(d, 3'h0), 1'b0);
    end
    for (i = 0; i < 4; i = i + 1) begin
      d = {8'hF0, 13'h1F80, 1'b1, i[1:0], 8'hA4};
      op(d, exp_code(d, 3'h0), 1'b0);
    end
    $display("test csr and prom done");
    op(32'hF0000100, `RSA_REFRESH, 1'b1);
    init_active_i <= 1'b1;
    op(32'hF8000000, `RSA_INIT, 1'b1);
    init_active_i <= 1'b0;
    fast_speed_select_i <= 1'b0;
    op(32'hF0000200, `RSA_RD, 1'b0);
    fast_speed_select_i <= 1'b1;
    $display("test refresh and slow done");
    conclude;
  end
endmodule // testbench
bind memory_cycle_type_selector memory_cycle_type_selector_properties chk (.sys_clk_i, .rst_b_i,
  .correction_disable_i, .diag_check_i, .prom_chip_select_b_o, .csr_read_select_b_o, .datapath_output_code_o,
  .microcode_start_address_o, .init_cycle_b_o, .refresh_cycle_b_o, .illegal_csr_write_b_o, .busy_release_o,
  .diag_check_substitute_b_o, .ecc_bypass_o, .prom_word_valid_o);
